// ==== hdl/sso_pkg.sv ====
/*
 * Constants for the servo status output block: function codes,
 * register offsets, reset values and timing figures.
 * Assumes a 10 MHz control clock and an AXI4-Lite master.
 */
// What this block does
// - Code 04: speed reached, held until speed drops
// - Code 05: in position when error within window, pulse position mode only
// - Code 06: torque at limit, not torque modes
// - Code 07: fault output on other faults and overload alarm only
// - Limit, stop, comm, undervoltage faults warn first
// - Code 08: brake control with two delays
// - Warning time is permissible time times percentage
// - Overload warning once accumulated time exceeds threshold
// - Over permissible time: alarm code and fault output
// - Function code zero leaves output inactive
// - Code 11: warning on the warn-first faults
package sso_pkg;

   // ****************************************************************
   // Function codes
   // ****************************************************************
   localparam logic [7:0] FN_OFF     = 8'h00;
   localparam logic [7:0] FN_SPEED   = 8'h04;
   localparam logic [7:0] FN_INPOS   = 8'h05;
   localparam logic [7:0] FN_TORQUE  = 8'h06;
   localparam logic [7:0] FN_FAULT   = 8'h07;
   localparam logic [7:0] FN_BRAKE   = 8'h08;
   localparam logic [7:0] FN_OLWARN  = 8'h10;
   localparam logic [7:0] FN_WARN    = 8'h11;

   localparam int NUM_OUT = 6;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFS_FUNC0   = 8'h00; // outputs 0..3 codes
   localparam logic [7:0] OFS_FUNC1   = 8'h04; // outputs 4..5 codes
   localparam logic [7:0] OFS_SPEED   = 8'h08; // target speed
   localparam logic [7:0] OFS_WINDOW  = 8'h0C; // position window
   localparam logic [7:0] OFS_TLIMIT  = 8'h10; // torque limit
   localparam logic [7:0] OFS_BRAKE1  = 8'h14; // on delay, ms
   localparam logic [7:0] OFS_BRAKE2  = 8'h18; // off delay, ms
   localparam logic [7:0] OFS_OLPCT   = 8'h1C; // warning percentage
   localparam logic [7:0] OFS_OLTIME  = 8'h20; // permissible time, ms
   localparam logic [7:0] OFS_CTRL    = 8'h24; // modes and enable
   localparam logic [7:0] OFS_STATUS  = 8'h28; // live outputs, alarm
   localparam logic [7:0] OFS_IRQ     = 8'h2C; // sticky events, W1C
   localparam logic [7:0] OFS_MASK    = 8'h30; // interrupt mask
   localparam logic [7:0] OFS_OLACC   = 8'h34; // accumulated ms

   // Control register fields
   localparam int CTRL_SERVO_ON   = 0;
   localparam int CTRL_PULSE_POS  = 1;
   localparam int CTRL_TORQUE_MOD = 2;
   localparam int CTRL_EXT_TLIM   = 3;

   // Fault input bit positions
   localparam int FLT_REV_LIMIT = 0;
   localparam int FLT_FWD_LIMIT = 1;
   localparam int FLT_ESTOP     = 2;
   localparam int FLT_COMM      = 3;
   localparam int FLT_UNDERVOLT = 4;
   localparam int FLT_OTHER     = 5;
   localparam int NUM_FLT       = 6;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] RST_FUNC0  = 32'h0706_0504;
   localparam logic [31:0] RST_FUNC1  = 32'h0000_1008;
   localparam logic [15:0] RST_SPEED  = 16'h0BB8;
   localparam logic [15:0] RST_WINDOW = 16'h0064;
   localparam logic [15:0] RST_TLIMIT = 16'h0064;
   localparam logic [15:0] RST_DELAY  = 16'h0000;
   localparam logic [7:0]  RST_OLPCT  = 8'h3C;
   localparam logic [15:0] RST_OLTIME = 16'h1F40;
   localparam logic [7:0]  OL_ALARM_CODE = 8'h06;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ   = 10_000_000;
   localparam int TICK_NS  = 1_000_000;  // one millisecond
   localparam int TICK_CYC = TICK_NS / (1_000_000_000 / CLK_HZ);

endpackage : sso_pkg

// ==== hdl/sso_status_out.sv ====
/*
 * Servo status output logic: six level outputs, each picking a
 * function by code; overload timer, brake sequencer, AXI4-Lite slave.
 * Assumes measurements arrive synchronous to aclk from the loops.
 */
`timescale 1ns/1ps
`default_nettype none
module sso_status_out
   import sso_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   input  wire logic [15:0]          motor_speed,
   input  wire logic [15:0]          position_error,
   input  wire logic [15:0]          motor_torque,
   input  wire logic [15:0]          ext_torque_limit,
   input  wire logic                 overloaded,
   input  wire logic [NUM_FLT-1:0]   fault_in,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [NUM_OUT-1:0]        status_out,
   output logic [7:0]                alarm_code,
   output logic                      irq
);

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic [31:0] func0, func1;
   logic [15:0] target_speed, pos_window, torque_limit;
   logic [15:0] brake_on_delay, brake_off_delay, ol_time_ms;
   logic [7:0]  ol_pct;
   logic [3:0]  ctrl;
   logic [5:0]  irq_stat, irq_mask;

   // ****************************************************************
   // Millisecond tick
   // ****************************************************************
   logic [23:0] tick_cnt;
   logic        tick;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= '0;
      end else if (ce) begin
         if (tick_cnt == 24'(TICK_CYCLES - 1)) tick_cnt <= '0;
         else tick_cnt <= tick_cnt + 24'h000001;
      end
   end
   assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));

   // ****************************************************************
   // Overload accumulation
   // ****************************************************************
   logic [15:0] ol_acc;
   logic [23:0] ol_warn_scaled;
   logic        ol_warn, ol_alarm;
   // Threshold in ms*100 avoids a divider
   // Widen before the product: 8000 ms at 60 % overflows 16 bits
   assign ol_warn_scaled = 24'(ol_time_ms) * 24'(ol_pct);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ol_acc <= '0;
      end else if (ce) begin
         if (!overloaded) ol_acc <= '0;
         else if (tick && ol_acc != 16'hFFFF)
            ol_acc <= ol_acc + 16'h0001;
      end
   end
   assign ol_warn = 24'(ol_acc) * 24'h000064 > ol_warn_scaled;
   // Alarm latches until reset; an overload trip needs attention
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ol_alarm <= 1'b0;
      end else if (ce && ol_acc > ol_time_ms) begin
         ol_alarm <= 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) alarm_code <= 8'h00;
      else if (ce) alarm_code <= ol_alarm ? OL_ALARM_CODE : 8'h00;
   end

   // ****************************************************************
   // Fault classification
   // ****************************************************************
   logic warn_fault, any_fault;
   assign warn_fault = |fault_in[FLT_UNDERVOLT:FLT_REV_LIMIT];
   // Warn-class faults do not drive the fault output first
   assign any_fault = fault_in[FLT_OTHER] | ol_alarm;

   // ****************************************************************
   // Brake sequencer
   // ****************************************************************
   logic        brake_engaged, servo_q;
   logic [15:0] brake_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brake_engaged <= 1'b1;
         servo_q       <= 1'b0;
         brake_cnt     <= '0;
      end else if (ce) begin
         servo_q <= ctrl[CTRL_SERVO_ON];
         if (ctrl[CTRL_SERVO_ON] != servo_q) begin
            brake_cnt <= '0;
         end else if (ctrl[CTRL_SERVO_ON] && brake_engaged) begin
            if (brake_cnt >= brake_on_delay) brake_engaged <= 1'b0;
            else if (tick) brake_cnt <= brake_cnt + 16'h0001;
         end else if (!ctrl[CTRL_SERVO_ON] && !brake_engaged) begin
            if (brake_cnt >= brake_off_delay || motor_speed < target_speed)
               brake_engaged <= 1'b1;
            else if (tick) brake_cnt <= brake_cnt + 16'h0001;
         end
      end
   end

   // ****************************************************************
   // Output selection
   // ****************************************************************
   function automatic logic pick(input logic [7:0] code,
                                 input logic [7:0] conds);
      unique case (code)
         FN_SPEED:  pick = conds[0];
         FN_INPOS:  pick = conds[1];
         FN_TORQUE: pick = conds[2];
         FN_FAULT:  pick = conds[3];
         FN_BRAKE:  pick = conds[4];
         FN_OLWARN: pick = conds[5];
         FN_WARN:   pick = conds[6];
         default:   pick = 1'b0;
      endcase
   endfunction : pick

   logic [7:0]  conds;
   logic [15:0] tlim;
   assign tlim = ctrl[CTRL_EXT_TLIM] ? ext_torque_limit : torque_limit;
   assign conds[0] = motor_speed >= target_speed;
   assign conds[1] = ctrl[CTRL_PULSE_POS] &&
                     position_error <= pos_window;
   assign conds[2] = !ctrl[CTRL_TORQUE_MOD] &&
                     motor_torque >= tlim;
   assign conds[3] = any_fault;
   assign conds[4] = brake_engaged;
   assign conds[5] = ol_warn;
   assign conds[6] = warn_fault;
   assign conds[7] = 1'b0;

   logic [7:0] codes [NUM_OUT];
   always_comb begin
      for (int i = 0; i < 4; i++) codes[i] = func0[8*i +: 8];
      for (int i = 4; i < NUM_OUT; i++) codes[i] = func1[8*(i-4) +: 8];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_out <= '0;
      end else if (ce) begin
         for (int i = 0; i < NUM_OUT; i++)
            status_out[i] <= pick(codes[i], conds);
      end
   end

   // ****************************************************************
   // Interrupts: events are rising edges of the six conditions
   // ****************************************************************
   logic [5:0] ev_now, ev_last;
   assign ev_now = {ol_alarm, warn_fault, any_fault, ol_warn,
                    conds[1], conds[0]};
   logic       wr_go;
   logic [7:0] wr_addr;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_last  <= '0;
         irq_stat <= '0;
      end else if (ce) begin
         ev_last <= ev_now;
         // Set beats clear in the same cycle
         irq_stat <= (irq_stat &
                     ~((wr_go && wr_addr == OFS_IRQ && s_axi_wstrb[0])
                       ? s_axi_wdata[5:0] : 6'h00))
                     | (ev_now & ~ev_last);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) irq <= 1'b0;
      else if (ce) irq <= |(irq_stat & irq_mask);
   end

   // ****************************************************************
   // AXI4-Lite write
   // ****************************************************************
   logic aw_have, w_have;
   logic [31:0] wdata_q;
   assign wr_addr = s_axi_awaddr;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else if (ce) begin
         s_axi_awready <= wr_go && !s_axi_awready;
         s_axi_wready  <= wr_go && !s_axi_awready;
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr <= OFS_OLACC &&
                             s_axi_awaddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      for (int b = 0; b < 4; b++)
         merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
   endfunction : merge

   logic wr_now;
   assign wr_now = s_axi_awready && s_axi_wready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         func0 <= RST_FUNC0;           func1 <= RST_FUNC1;
         target_speed <= RST_SPEED;    pos_window <= RST_WINDOW;
         torque_limit <= RST_TLIMIT;   brake_on_delay <= RST_DELAY;
         brake_off_delay <= RST_DELAY; ol_pct <= RST_OLPCT;
         ol_time_ms <= RST_OLTIME;     ctrl <= 4'h0;
         irq_mask <= 6'h00;
      end else if (ce && wr_now) begin
         unique case (s_axi_awaddr)
            OFS_FUNC0:  func0 <= merge(func0, s_axi_wdata, s_axi_wstrb);
            OFS_FUNC1:  func1 <= merge(func1, s_axi_wdata, s_axi_wstrb);
            OFS_SPEED:  target_speed <= 16'(merge({16'h0, target_speed},
                           s_axi_wdata, s_axi_wstrb));
            OFS_WINDOW: pos_window <= 16'(merge({16'h0, pos_window},
                           s_axi_wdata, s_axi_wstrb));
            OFS_TLIMIT: torque_limit <= 16'(merge({16'h0, torque_limit},
                           s_axi_wdata, s_axi_wstrb));
            OFS_BRAKE1: brake_on_delay <= 16'(merge({16'h0, brake_on_delay},
                           s_axi_wdata, s_axi_wstrb));
            OFS_BRAKE2: brake_off_delay <= 16'(merge({16'h0,
                           brake_off_delay}, s_axi_wdata, s_axi_wstrb));
            OFS_OLPCT:  if (s_axi_wstrb[0]) ol_pct <= s_axi_wdata[7:0];
            OFS_OLTIME: ol_time_ms <= 16'(merge({16'h0, ol_time_ms},
                           s_axi_wdata, s_axi_wstrb));
            OFS_CTRL:   if (s_axi_wstrb[0]) ctrl <= s_axi_wdata[3:0];
            OFS_MASK:   if (s_axi_wstrb[0]) irq_mask <= s_axi_wdata[5:0];
            default:    ;
         endcase
      end
   end

   // ****************************************************************
   // AXI4-Lite read
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= 2'b00;
      end else if (ce) begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (s_axi_araddr)
               OFS_FUNC0:  s_axi_rdata <= func0;
               OFS_FUNC1:  s_axi_rdata <= func1;
               OFS_SPEED:  s_axi_rdata <= {16'h0, target_speed};
               OFS_WINDOW: s_axi_rdata <= {16'h0, pos_window};
               OFS_TLIMIT: s_axi_rdata <= {16'h0, torque_limit};
               OFS_BRAKE1: s_axi_rdata <= {16'h0, brake_on_delay};
               OFS_BRAKE2: s_axi_rdata <= {16'h0, brake_off_delay};
               OFS_OLPCT:  s_axi_rdata <= {24'h0, ol_pct};
               OFS_OLTIME: s_axi_rdata <= {16'h0, ol_time_ms};
               OFS_CTRL:   s_axi_rdata <= {28'h0, ctrl};
               OFS_STATUS: s_axi_rdata <= {16'h0, alarm_code,
                                           2'b00, status_out};
               OFS_IRQ:    s_axi_rdata <= {26'h0, irq_stat};
               OFS_MASK:   s_axi_rdata <= {26'h0, irq_mask};
               OFS_OLACC:  s_axi_rdata <= {16'h0, ol_acc};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : sso_status_out
`default_nettype wire

// ==== tb/sso_status_out_props.sv ====
/* Checker for the status output block, watching top ports only.
   Assumes ce held high and a single-beat AXI4-Lite master. */
`timescale 1ns/1ps
`default_nettype none
module sso_status_out_props
   import sso_pkg::*;
#(
   parameter int TICK_CYCLES = 4
) (
   input wire logic               aclk,
   input wire logic               aresetn,
   input wire logic               overloaded,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [NUM_OUT-1:0] status_out,
   input wire logic [7:0]         alarm_code,
   input wire logic               irq
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_reset_clear;
      $rose(aresetn) |-> status_out == '0 && alarm_code == 8'h00 && !irq;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
   property p_alarm_val;
      alarm_code == 8'h00 || alarm_code == 8'h06;
   endproperty
   a_alarm_val: assert property (p_alarm_val) else $error("bad alarm code");
   property p_alarm_latch;
      alarm_code != 8'h00 |=> alarm_code == 8'h06;
   endproperty
   a_alarm_latch: assert property (p_alarm_latch) else $error("alarm lost");
   // Alarm rise must follow overload sampled three cycles before it
   property p_alarm_cause;
      $rose(alarm_code != 8'h00) |-> $past(overloaded, 3);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without overload");
   property p_wr_accept;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
         |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
   endproperty
   a_wr_accept: assert property (p_wr_accept) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_rd_accept;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
         |=> s_axi_arready ##1 s_axi_rvalid;
   endproperty
   a_rd_accept: assert property (p_rd_accept) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read:  cover property (s_axi_rvalid && s_axi_rready);
   c_alarm: cover property ($rose(alarm_code != 8'h00));
endmodule : sso_status_out_props
`default_nettype wire

// ==== tb/sso_plc_model.sv ====
/* Far-side controller model: scans the discrete outputs once a cycle.
   Assumes it shares aclk and reset with the status output block. */
`timescale 1ns/1ps
`default_nettype none
module sso_plc_model
   import sso_pkg::*;
(
   input  wire logic [NUM_OUT-1:0] status_in,
   input  wire logic               aclk,
   input  wire logic               aresetn,
   output logic      [NUM_OUT-1:0] seen
);
   // ****************************************************************
   // Input scan
   // ****************************************************************
   // One scan of latency, as an input card would add
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen <= '0;
      end else begin
         seen <= status_in;
      end
   end
endmodule : sso_plc_model
`default_nettype wire

// ==== tb/tb.sv ====
/* Self-checking bench for the status output block over AXI4-Lite.
   Assumes the checker and controller model files of tb/. */
`timescale 1ns/1ps
`default_nettype none
module tb
   import sso_pkg::*;
();
   // ****************************************************************
   // Signals and design
   // ****************************************************************
   localparam int TICKS = 4;
   logic               aclk = 1'b0, aresetn = 1'b0, overloaded = 1'b0;
   logic [15:0]        motor_speed = '0, position_error = '0;
   logic [15:0]        motor_torque = '0, ext_torque_limit = '0;
   logic [NUM_FLT-1:0] fault_in = '0;
   logic [7:0]         awaddr = '0, araddr = '0;
   logic [31:0]        wdata = '0, rdata;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic               arvalid = 1'b0, rready = 1'b0;
   logic               awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]         bresp, rresp;
   logic [NUM_OUT-1:0] status_out, seen;
   logic [7:0]         alarm_code;
   int                 num_errors = 0, compares = 0;
   logic [15:0]        spd_tab [4] = '{16'h0BB7, 16'h0BB8, 16'h0FA0, 16'h0BB7};
   logic [3:0]         spd_exp = 4'h6;
   logic [7:0]         fcode [3] = '{8'h07, 8'h11, 8'h00};
   logic [5:0]         fexp [3] = '{6'h20, 6'h1F, 6'h00};

   always #50 aclk = ~aclk;

   sso_status_out #(.TICK_CYCLES(TICKS)) uut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .motor_speed(motor_speed), .position_error(position_error),
      .motor_torque(motor_torque), .ext_torque_limit(ext_torque_limit),
      .overloaded(overloaded), .fault_in(fault_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .status_out(status_out), .alarm_code(alarm_code), .irq(irq));
   sso_plc_model plc (.status_in(status_out), .aclk(aclk),
      .aresetn(aresetn), .seen(seen));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk(32'(bresp), 32'h0);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask : rchk
   task automatic stop_test;
      if (num_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      #2_000_000;
      num_errors++;
      stop_test();
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      wt(3);
      aresetn <= 1'b1;
      wt(3);
      chk(32'(seen), 32'h0000_0010);
      rchk(OFS_FUNC0, RST_FUNC0, 2'h0);
      rchk(OFS_FUNC1, RST_FUNC1, 2'h0);
      rchk(OFS_SPEED, 32'(RST_SPEED), 2'h0);
      rchk(8'h3C, 32'h0, 2'h2);
      foreach (spd_tab[i]) begin
         motor_speed <= spd_tab[i];
         wt(3);
         chk(32'(seen[0]), 32'(spd_exp[i]));
      end
      position_error <= 16'h0064;
      wt(3);
      chk(32'(seen[1]), 32'h0);
      wr(OFS_CTRL, 32'h0000_0002);
      wt(3);
      chk(32'(seen[1]), 32'h1);
      position_error <= 16'h0065;
      wt(3);
      chk(32'(seen[1]), 32'h0);
      motor_torque <= 16'h0064;
      wt(3);
      chk(32'(seen[2]), 32'h1);
      motor_torque <= 16'h0063;
      wt(3);
      chk(32'(seen[2]), 32'h0);
      ext_torque_limit <= 16'h0032;
      wr(OFS_CTRL, 32'h0000_0008);
      wt(3);
      chk(32'(seen[2]), 32'h1);
      wr(OFS_CTRL, 32'h0000_000C);
      wt(3);
      chk(32'(seen[2]), 32'h0);
      for (int c = 0; c < 3; c++) begin
         wr(OFS_FUNC0, {fcode[c], 24'h06_0504});
         for (int b = 0; b < NUM_FLT; b++) begin
            fault_in <= 6'h01 << b;
            wt(3);
            chk(32'(seen[3]), 32'(fexp[c][b]));
         end
         fault_in <= '0;
      end
      wr(OFS_FUNC0, RST_FUNC0);
      motor_speed <= 16'h1388;
      wr(OFS_BRAKE1, 32'h0000_0003);
      wr(OFS_BRAKE2, 32'h0000_0003);
      wr(OFS_CTRL, 32'h0000_0001);
      wt(1);
      chk(32'(seen[4]), 32'h1);
      wt(20);
      chk(32'(seen[4]), 32'h0);
      wr(OFS_CTRL, 32'h0000_0000);
      wt(1);
      chk(32'(seen[4]), 32'h0);
      wt(20);
      chk(32'(seen[4]), 32'h1);
      wr(OFS_CTRL, 32'h0000_0001);
      wt(25);
      motor_speed <= 16'h0000;
      wr(OFS_CTRL, 32'h0000_0000);
      // Servo edge, engage, output, scan: four edges
      wt(4);
      chk(32'(seen[4]), 32'h1);
      wr(OFS_OLTIME, 32'h0000_000A);
      wr(OFS_MASK, 32'h0000_0004);
      wr(OFS_IRQ, 32'h0000_003F);
      overloaded <= 1'b1;
      wt(20);
      chk(32'(seen[5]), 32'h0);
      wt(16);
      chk(32'(seen[5]), 32'h1);
      chk(32'(alarm_code), 32'h0);
      chk(32'(irq), 32'h1);
      wt(20);
      chk(32'(alarm_code), 32'h0000_0006);
      chk(32'(seen[3]), 32'h1);
      rd(OFS_IRQ, d, r);
      chk(d & 32'h0000_0004, 32'h0000_0004);
      wr(OFS_IRQ, 32'h0000_0004);
      wt(2);
      chk(32'(irq), 32'h0);
      overloaded <= 1'b0;
      wt(8);
      chk(32'(seen[5]), 32'h0);
      chk(32'(alarm_code), 32'h0000_0006);
      aresetn <= 1'b0;
      wt(3);
      aresetn <= 1'b1;
      wt(3);
      chk(32'(alarm_code), 32'h0);
      stop_test();
   end
endmodule : tb

bind sso_status_out sso_status_out_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .aclk(aclk), .aresetn(aresetn), .overloaded(overloaded),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .status_out(status_out),
   .alarm_code(alarm_code), .irq(irq));
`default_nettype wire
